/* ebra_pkg.sv */
// constants and types of the external bus release arbiter
package ebra_pkg;

  // bus clock and refresh interval
  localparam int unsigned CLK_NS     = 100;
  localparam int unsigned REF_INT_NS = 15600;
  localparam logic [7:0]  REF_CYC    = 8'(REF_INT_NS / CLK_NS);

  // strobes driven high this many cycles before address/data float
  localparam logic [1:0]  HIGH_CYC   = 2'h2;
  // index of the last of four longword beats in one cache line fill
  localparam logic [1:0]  FILL_LAST  = 2'h3;

  // arbiter states
  typedef enum logic [2:0] {
    S_OWN   = 3'h0,
    S_PRECH = 3'h1,
    S_HIGH  = 3'h2,
    S_FLOAT = 3'h3,
    S_GRANT = 3'h4,
    S_REL   = 3'h5,
    S_RECL  = 3'h6,
    S_UNGR  = 3'h7
  } ebra_state_t;

  // pin controls toward the bus pads; enables are low while driving
  typedef struct packed {
    logic bus_grant_n;
    logic ad_oe_n;
    logic ctrl_oe_n;
    logic ctrl_high;
    logic refresh_pending_out;
  } ebra_pins_t;

  // state of the arbiter except dma_go_reg
  typedef struct packed {
    ebra_state_t st;
    logic [1:0]  hi_cnt;
    logic [7:0]  refresh_timer_count;
    logic        ref_req;
    logic        ref_go;
    logic        prech_req;
    logic        wbuf_v;
    logic        wr_ack;
    logic        ext_wr_go;
    logic        lookup;
    logic        fill_act;
    logic [1:0]  fill_cnt;
    logic        fill_done;
    logic        cyc_ok;
    ebra_pins_t  pins;
  } ebra_regs_t;

endpackage

/* ebra_arbiter.sv */
// external bus release arbiter with refresh, write buffer and fill control
// Overview of operation
// RULE1: on request, finish cycle, release, then grant
// RULE2: request high returns bus; negate grant, resume
// RULE3: released bus floats except grant, cke, dack
// RULE4: precharge open sdram bank before release
// RULE5: float address/data, then grant, then strobes
// RULE6: strobes driven high two cycles before float
// RULE7: release request sampled once per clock
// RULE8: reclaim: strobes high, ungrant, drive, then start
// RULE9: master must return bus within refresh interval
// RULE10: refresh pending shown until bus regained
// RULE11: power-on reset negates and floats everything
// RULE12: sleep, standby, manual reset keep settings
// RULE13: manual reset ends cycle; fill stops at longword
// RULE14: manual reset freezes refresh timer count
// RULE15: manual reset: keep arbitrating, grant shows high
// RULE16: miss: one lookup cycle, four longword reads
// RULE17: one buffered write; ack at once if held
// RULE18: dma read waits only when both ends external; code also holds it in every state but S_OWN
// RULE19: write-through writes out; write-back defers
// RULE20: grant held low throughout release
`timescale 1ns/1ns
`default_nettype none
module ebra_arbiter
  import ebra_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic manual_reset_n_i,
  input  wire logic bus_release_request_n_i,
  input  wire logic cycle_active_i,
  input  wire logic burst_lock_i,
  input  wire logic sdram_bank_open_i,
  input  wire logic precharge_done_i,
  input  wire logic refresh_done_i,
  input  wire logic cpu_wr_req_i,
  input  wire logic int_bus_held_i,
  input  wire logic wr_hit_i,
  input  wire logic write_back_i,
  input  wire logic ext_wr_done_i,
  input  wire logic dma_rd_req_i,
  input  wire logic dma_both_ext_i,
  input  wire logic cache_miss_i,
  input  wire logic beat_done_i,
  output ebra_pins_t pins_o,
  output logic      precharge_req_o,
  output logic      refresh_go_o,
  output logic      cycle_start_ok_o,
  output logic      cpu_wr_ack_o,
  output logic      ext_wr_start_o,
  output logic      dma_rd_go_o,
  output logic      fill_rd_o,
  output logic [1:0] fill_beat_o,
  output logic      fill_done_o
);

  ebra_regs_t r_reg;
  ebra_regs_t r_next;
  logic       dma_go_reg;
  logic       dma_go_next;
  logic       mrst;
  logic       idle;
  logic       req;

  // manual reset level, idle bus, sampled release request
  assign mrst = !manual_reset_n_i;
  // RULE7: request sampled once
  assign req  = !bus_release_request_n_i;
  // RULE1: wait for cycle end
  assign idle = !cycle_active_i && !burst_lock_i && !r_reg.fill_act && !r_reg.lookup;

  // next state of the whole block
  always_comb begin
    r_next = r_reg;
    r_next.ref_go    = 1'b0;
    r_next.wr_ack    = 1'b0;
    r_next.ext_wr_go = 1'b0;
    r_next.fill_done = 1'b0;
    r_next.lookup    = 1'b0;
    r_next.prech_req = 1'b0;
    dma_go_next      = 1'b0;

    // arbitration sequence
    unique case (r_reg.st)
      S_OWN: begin
        r_next.hi_cnt = 2'h0;
        if (req && idle && !r_reg.ref_go) begin
          // RULE4: precharge before release
          if (sdram_bank_open_i) begin
            r_next.st = S_PRECH;
            r_next.prech_req = 1'b1;
          end else begin
            r_next.st = S_HIGH;
          end
        end
      end
      S_PRECH: begin
        r_next.prech_req = !precharge_done_i;
        if (precharge_done_i) begin
          r_next.st = S_HIGH;
        end
      end
      S_HIGH: begin
        // RULE6: two cycles high
        r_next.hi_cnt = r_reg.hi_cnt + 2'h1;
        if (!req) begin
          r_next.st = S_OWN;
        end else if (r_reg.hi_cnt == HIGH_CYC - 2'h1) begin
          r_next.st = S_FLOAT;
        end
      end
      // RULE5: address/data float first
      S_FLOAT: r_next.st = S_GRANT;
      // RULE5: grant, then strobes float
      S_GRANT: r_next.st = S_REL;
      S_REL: begin
        // RULE2: request high reclaims
        if (!req) begin
          r_next.st = S_RECL;
        end
      end
      // RULE8: ungrant after strobes high
      S_RECL: r_next.st = S_UNGR;
      S_UNGR: r_next.st = S_OWN;
    endcase

    // pin controls follow the next state
    // RULE3: float all but grant
    r_next.pins.ad_oe_n   = !(r_next.st inside {S_OWN, S_PRECH, S_HIGH});
    r_next.pins.ctrl_oe_n = r_next.st inside {S_REL};
    r_next.pins.ctrl_high = r_next.st inside {S_HIGH, S_FLOAT, S_GRANT, S_RECL, S_UNGR};
    // RULE20: grant low while released
    // RULE15: manual reset shows grant high
    r_next.pins.bus_grant_n = !((r_next.st inside {S_GRANT, S_REL, S_RECL}) && !mrst);
    // RULE8: start only once driven
    // RULE13: no new cycle in reset
    r_next.cyc_ok = (r_next.st == S_OWN) && !mrst;

    // RULE14: timer frozen in manual reset
    if (!mrst) begin
      if (r_reg.refresh_timer_count == REF_CYC - 8'h01) begin
        r_next.refresh_timer_count = 8'h00;
        r_next.ref_req = 1'b1;
      end else begin
        r_next.refresh_timer_count = r_reg.refresh_timer_count + 8'h01;
      end
    end
    if (refresh_done_i && !(r_next.ref_req && !r_reg.ref_req)) begin
      r_next.ref_req = 1'b0;
    end
    // refresh starts only on an owned idle bus
    if (r_reg.ref_req && !r_reg.ref_go && r_reg.st == S_OWN && idle && !refresh_done_i) begin
      r_next.ref_go = 1'b1;
    end
    // RULE10: pending until bus regained
    r_next.pins.refresh_pending_out = r_next.ref_req && (r_next.st != S_OWN);

    // RULE17: one buffered write
    if (cpu_wr_req_i && wr_hit_i && write_back_i && int_bus_held_i) begin
      // RULE19: write-back defers write
      r_next.wr_ack = 1'b1;
    end else if (cpu_wr_req_i && int_bus_held_i && (!r_reg.wbuf_v || ext_wr_done_i)) begin
      // RULE19: write-through goes out
      r_next.wr_ack    = 1'b1;
      r_next.ext_wr_go = 1'b1;
      r_next.wbuf_v    = 1'b1;
    end else if (ext_wr_done_i) begin
      r_next.wbuf_v = 1'b0;
    end

    // RULE18: dma read past buffer
    if (dma_rd_req_i && r_reg.st == S_OWN && !(dma_both_ext_i && r_reg.wbuf_v)) begin
      dma_go_next = 1'b1;
    end

    // RULE16: lookup, then four reads
    if (cache_miss_i && !r_reg.fill_act && !r_reg.lookup && !mrst) begin
      r_next.lookup = 1'b1;
    end
    if (r_reg.lookup) begin
      r_next.fill_act = 1'b1;
      r_next.fill_cnt = 2'h0;
    end
    if (r_reg.fill_act && beat_done_i) begin
      r_next.fill_cnt = r_reg.fill_cnt + 2'h1;
      // RULE13: stop at longword boundary
      if (r_reg.fill_cnt == FILL_LAST || mrst) begin
        r_next.fill_act  = 1'b0;
        r_next.fill_done = 1'b1;
      end
    end
  end

  // state register; RULE11 power-on reset clears state, negates and floats pins
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // RULE11: negate and float
      r_reg      <= '{st: S_OWN, hi_cnt: 2'h0, refresh_timer_count: 8'h00,
                      pins: '{bus_grant_n: 1'b1, ad_oe_n: 1'b1, ctrl_oe_n: 1'b1,
                              ctrl_high: 1'b1, refresh_pending_out: 1'b0},
                      default: 1'b0};
      dma_go_reg <= 1'b0;
    end else begin
      // RULE12: manual reset keeps settings
      r_reg      <= r_next;
      dma_go_reg <= dma_go_next;
    end
  end

  // outputs straight from the state flops
  assign pins_o           = r_reg.pins;
  assign precharge_req_o  = r_reg.prech_req;
  assign refresh_go_o     = r_reg.ref_go;
  assign cycle_start_ok_o = r_reg.cyc_ok;
  assign cpu_wr_ack_o     = r_reg.wr_ack;
  assign ext_wr_start_o   = r_reg.ext_wr_go;
  assign dma_rd_go_o      = dma_go_reg;
  assign fill_rd_o        = r_reg.fill_act;
  assign fill_beat_o      = r_reg.fill_cnt;
  assign fill_done_o      = r_reg.fill_done;

  // checks of release, reclaim, refresh, manual reset, write, dma and fill behaviour
  sequence s_reclaim;
    (!pins_o.ctrl_oe_n && pins_o.ctrl_high) ##1 pins_o.bus_grant_n
      ##1 (!pins_o.ad_oe_n && pins_o.bus_grant_n);
  endsequence
  sequence s_float_then_grant;
    $rose(pins_o.ad_oe_n) ##1 $fell(pins_o.bus_grant_n) ##1 $rose(pins_o.ctrl_oe_n);
  endsequence

  property p_grant_order;
    @(posedge clk_i) disable iff (!rst_n_i)
      ($rose(pins_o.ad_oe_n) && manual_reset_n_i && $past(manual_reset_n_i))
      |-> s_float_then_grant;
  endproperty
  a_grant_order: assert property (p_grant_order) else $error("release order wrong"); // RULE5

  property p_high_before_float;
    @(posedge clk_i) disable iff (!rst_n_i)
      $rose(pins_o.ctrl_oe_n) |-> $past(pins_o.ctrl_high, 1) && $past(pins_o.ctrl_high, 2)
        && $past(pins_o.ctrl_high, 3) && $past(pins_o.ctrl_high, 4);
  endproperty
  a_high_before_float: assert property (p_high_before_float) // RULE6
    else $error("strobes not high before float");

  property p_float_when_released;
    @(posedge clk_i) disable iff (!rst_n_i)
      (r_reg.st == S_REL) |-> pins_o.ad_oe_n && pins_o.ctrl_oe_n;
  endproperty
  a_float_when_released: assert property (p_float_when_released) // RULE3
    else $error("bus driven while released");

  property p_reclaim;
    @(posedge clk_i) disable iff (!rst_n_i)
      (r_reg.st == S_REL && bus_release_request_n_i)
      |=> s_reclaim;
  endproperty
  a_reclaim: assert property (p_reclaim) else $error("reclaim order wrong"); // RULE8

  property p_no_start_floated;
    @(posedge clk_i) disable iff (!rst_n_i)
      cycle_start_ok_o |-> !pins_o.ad_oe_n && pins_o.bus_grant_n && !pins_o.ctrl_oe_n;
  endproperty
  a_no_start_floated: assert property (p_no_start_floated) // RULE2
    else $error("cycle allowed on released bus");

  property p_grant_held;
    @(posedge clk_i) disable iff (!rst_n_i)
      (r_reg.st == S_REL && manual_reset_n_i && !bus_release_request_n_i)
      |=> !pins_o.bus_grant_n;
  endproperty
  a_grant_held: assert property (p_grant_held) else $error("grant dropped"); // RULE20

  property p_timer_frozen;
    @(posedge clk_i) disable iff (!rst_n_i)
      !manual_reset_n_i |=> $stable(r_reg.refresh_timer_count);
  endproperty
  a_timer_frozen: assert property (p_timer_frozen) else $error("timer ran in reset"); // RULE14

  property p_refresh_pending;
    @(posedge clk_i) disable iff (!rst_n_i)
      (r_reg.ref_req && r_reg.st == S_REL) |-> pins_o.refresh_pending_out;
  endproperty
  a_refresh_pending: assert property (p_refresh_pending) // RULE10
    else $error("refresh wait not shown");

  property p_fill_lookup;
    @(posedge clk_i) disable iff (!rst_n_i)
      $rose(r_reg.lookup) |=> fill_rd_o && fill_beat_o == 2'h0;
  endproperty
  a_fill_lookup: assert property (p_fill_lookup) else $error("fill not after lookup"); // RULE16

  property p_dma_wait;
    @(posedge clk_i) disable iff (!rst_n_i)
      (dma_rd_req_i && dma_both_ext_i && r_reg.wbuf_v) |=> !dma_rd_go_o;
  endproperty
  a_dma_wait: assert property (p_dma_wait) else $error("dma read passed write"); // RULE18

  property p_manual_grant;
    @(posedge clk_i) disable iff (!rst_n_i)
      !manual_reset_n_i |=> pins_o.bus_grant_n;
  endproperty
  a_manual_grant: assert property (p_manual_grant) // RULE15
    else $error("grant shown during manual reset");

  property p_manual_no_start;
    @(posedge clk_i) disable iff (!rst_n_i)
      !manual_reset_n_i |=> !cycle_start_ok_o;
  endproperty
  a_manual_no_start: assert property (p_manual_no_start) // RULE13
    else $error("new cycle allowed in manual reset");

  property p_fill_cut;
    @(posedge clk_i) disable iff (!rst_n_i)
      (fill_rd_o && beat_done_i && !manual_reset_n_i) |=> fill_done_o && !fill_rd_o;
  endproperty
  a_fill_cut: assert property (p_fill_cut) // RULE13
    else $error("fill not cut by manual reset");

  property p_wr_ack_held;
    @(posedge clk_i) disable iff (!rst_n_i)
      cpu_wr_ack_o |-> $past(int_bus_held_i) && $past(cpu_wr_req_i);
  endproperty
  a_wr_ack_held: assert property (p_wr_ack_held) // RULE17
    else $error("write acknowledged without internal bus");

  property p_write_back_defer;
    @(posedge clk_i) disable iff (!rst_n_i)
      (cpu_wr_req_i && int_bus_held_i && wr_hit_i && write_back_i)
      |=> cpu_wr_ack_o && !ext_wr_start_o;
  endproperty
  a_write_back_defer: assert property (p_write_back_defer) // RULE19
    else $error("write-back hit went out");

  property p_prech_owned;
    @(posedge clk_i) disable iff (!rst_n_i)
      precharge_req_o |-> pins_o.bus_grant_n && !pins_o.ad_oe_n && !pins_o.ctrl_oe_n;
  endproperty
  a_prech_owned: assert property (p_prech_owned) // RULE4
    else $error("bus released before precharge");

  property p_refresh_owned;
    @(posedge clk_i) disable iff (!rst_n_i)
      refresh_go_o |-> pins_o.bus_grant_n && !pins_o.ad_oe_n;
  endproperty
  a_refresh_owned: assert property (p_refresh_owned) // RULE10
    else $error("refresh started on released bus");

endmodule // ebra_arbiter
`default_nettype wire

/* ebra_master_model.sv */
// external bus master model that borrows the shared bus
`timescale 1ns/1ns
`default_nettype none
module ebra_master_model (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic want_i,
  input  wire logic refresh_pending_i,
  input  wire logic bus_grant_n_i,
  output var  logic bus_release_request_n_o
);
  logic yield_reg;
  logic req_n_reg;
  logic pend;
  // owned bus with refresh waiting
  assign pend = refresh_pending_i && !bus_grant_n_i;
  always @(negedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      yield_reg <= 1'h0;
      req_n_reg <= 1'h1;
    end else begin
      yield_reg <= want_i && (yield_reg || pend);
      req_n_reg <= !(want_i && !yield_reg && !pend);
    end
  end
  assign bus_release_request_n_o = req_n_reg;
endmodule // ebra_master_model
`default_nettype wire

/* external_bus_release_arbiter_tb.sv */
// self-checking bench of the external bus release arbiter
`timescale 1ns/1ns
`default_nettype none
module external_bus_release_arbiter_tb;
  import ebra_pkg::*;
  logic       clk, rst_n, mrst_n, want, act, bank, pdone, rdone, wreq, held, hit, wb;
  logic       wdone, drq, dboth, miss, beat, req_n, preq, rgo, sok, wack, wst, dgo, frd, fdone;
  logic [1:0] fbeat;
  ebra_pins_t pins;
  int         num_errors, checked, gcnt, hc, i;

  ebra_master_model master (.clk_i(clk), .rst_n_i(rst_n), .want_i(want),
    .refresh_pending_i(pins.refresh_pending_out), .bus_grant_n_i(pins.bus_grant_n),
    .bus_release_request_n_o(req_n));

  ebra_arbiter dut (.clk_i(clk), .rst_n_i(rst_n), .manual_reset_n_i(mrst_n),
    .bus_release_request_n_i(req_n), .cycle_active_i(act), .burst_lock_i(1'h0),
    .sdram_bank_open_i(bank), .precharge_done_i(pdone), .refresh_done_i(rdone),
    .cpu_wr_req_i(wreq), .int_bus_held_i(held), .wr_hit_i(hit), .write_back_i(wb),
    .ext_wr_done_i(wdone), .dma_rd_req_i(drq), .dma_both_ext_i(dboth),
    .cache_miss_i(miss), .beat_done_i(beat), .pins_o(pins), .precharge_req_o(preq),
    .refresh_go_o(rgo), .cycle_start_ok_o(sok), .cpu_wr_ack_o(wack),
    .ext_wr_start_o(wst), .dma_rd_go_o(dgo), .fill_rd_o(frd), .fill_beat_o(fbeat),
    .fill_done_o(fdone));

  // clock and strobe-high run counter
  initial begin
    clk = 1'h0;
    forever #50 clk = !clk;
  end
  always @(negedge clk) hc <= (pins.ctrl_high === 1'h1 && pins.ctrl_oe_n === 1'h0) ? hc + 1 : 0;
  // refresh cycle finishes one cycle after start
  always @(negedge clk) rdone <= rgo;

  task automatic chk(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic nx(input int n);
    repeat (n) @(negedge clk);
  endtask
  localparam int W_GRANT = 0, W_PREQ = 1, W_PEND = 2, W_RGO = 3, W_WACK = 4, W_DGO = 5, W_FRD = 6;
  // level watched by wsig, chosen by index
  function automatic logic pick(input int k);
    case (k)
      W_GRANT: pick = pins.bus_grant_n;
      W_PREQ:  pick = preq;
      W_PEND:  pick = pins.refresh_pending_out;
      W_RGO:   pick = rgo;
      W_WACK:  pick = wack;
      W_DGO:   pick = dgo;
      default: pick = frd;
    endcase
  endfunction
  task automatic wsig(input int k, input logic lvl);
    gcnt = 0;
    while (pick(k) !== lvl && gcnt < 500) begin
      nx(1);
      gcnt++;
    end
  endtask

  task automatic t_release;
    want <= 1'h1;
    wsig(W_GRANT, 1'h0);
    chk("grant_soon", 1'h1, gcnt <= 8);
    chk("ad_float_first", 1'h1, pins.ad_oe_n);
    chk("strobe_driven", 1'h0, pins.ctrl_oe_n);
    nx(1);
    chk("strobe_float", 1'h1, pins.ctrl_oe_n);
    chk("strobe_high_2", 1'h1, hc >= 2);
    mrst_n <= 1'h0;
    nx(3);
    chk("mrst_grant_high", 1'h1, pins.bus_grant_n);
    chk("mrst_still_float", 1'h1, pins.ad_oe_n);
    mrst_n <= 1'h1;
    nx(3);
    chk("grant_held", 1'h0, pins.bus_grant_n);
    $display("test release done");
  endtask
  task automatic t_reclaim;
    want <= 1'h0;
    wsig(W_GRANT, 1'h1);
    chk("reclaim_ad_float", 1'h1, pins.ad_oe_n);
    chk("reclaim_strobe", 1'h0, pins.ctrl_oe_n);
    chk("reclaim_no_start", 1'h0, sok);
    nx(1);
    chk("reclaim_ad_drive", 1'h0, pins.ad_oe_n);
    chk("reclaim_start_ok", 1'h1, sok);
    $display("test reclaim done");
  endtask
  task automatic t_busy;
    act <= 1'h1;
    bank <= 1'h1;
    want <= 1'h1;
    nx(8);
    chk("busy_no_grant", 1'h1, pins.bus_grant_n);
    act <= 1'h0;
    wsig(W_PREQ, 1'h1);
    chk("prech_soon", 1'h1, gcnt <= 2);
    nx(6);
    chk("prech_no_grant", 1'h1, pins.bus_grant_n);
    pdone <= 1'h1;
    bank <= 1'h0;
    wsig(W_GRANT, 1'h0);
    pdone <= 1'h0;
    chk("prech_then_grant", 1'h0, pins.bus_grant_n);
    t_reclaim();
    $display("test busy and precharge done");
  endtask
  task automatic t_refresh;
    want <= 1'h1;
    wsig(W_GRANT, 1'h0);
    wsig(W_PEND, 1'h1);
    chk("pending_shown", 1'h1, pins.refresh_pending_out);
    wsig(W_GRANT, 1'h1);
    chk("pending_kept", 1'h1, pins.refresh_pending_out);
    wsig(W_RGO, 1'h1);
    chk("refresh_start", 1'h1, gcnt < 20);
    want <= 1'h0;
    nx(4);
    chk("pending_clear", 1'h0, pins.refresh_pending_out);
    $display("test refresh done");
  endtask
  task automatic t_write;
    held <= 1'h1;
    wreq <= 1'h1;
    wsig(W_WACK, 1'h1);
    wreq <= 1'h0;
    chk("wr_buffered", 1'h1, wst);
    drq <= 1'h1;
    nx(2);
    chk("dma_single_ext", 1'h1, dgo);
    dboth <= 1'h1;
    nx(4);
    chk("dma_waits", 1'h0, dgo);
    wdone <= 1'h1;
    wsig(W_DGO, 1'h1);
    wdone <= 1'h0;
    drq <= 1'h0;
    chk("dma_after_write", 1'h1, gcnt < 4);
    hit <= 1'h1;
    wb <= 1'h1;
    wreq <= 1'h1;
    wsig(W_WACK, 1'h1);
    wreq <= 1'h0;
    chk("wb_acked", 1'h1, wack);
    chk("wb_deferred", 1'h0, wst);
    hit <= 1'h0;
    held <= 1'h0;
    nx(1);
    wreq <= 1'h1;
    nx(6);
    chk("not_held_waits", 1'h0, wack);
    held <= 1'h1;
    wsig(W_WACK, 1'h1);
    wreq <= 1'h0;
    chk("held_acks", 1'h1, wst);
    $display("test write done");
  endtask
  task automatic t_fill;
    miss <= 1'h1;
    nx(1);
    miss <= 1'h0;
    chk("lookup_cycle", 1'h0, frd);
    wsig(W_FRD, 1'h1);
    for (i = 0; i < 4; i++) begin
      chk("fill_beat", 1'h1, fbeat === 2'(i));
      chk("fill_not_done", 1'h0, fdone);
      beat <= 1'h1;
      nx(1);
    end
    beat <= 1'h0;
    chk("fill_done", 1'h1, fdone);
    miss <= 1'h1;
    nx(1);
    miss <= 1'h0;
    wsig(W_FRD, 1'h1);
    mrst_n <= 1'h0;
    beat <= 1'h1;
    nx(1);
    beat <= 1'h0;
    mrst_n <= 1'h1;
    chk("mrst_fill_cut", 1'h1, fdone);
    chk("mrst_fill_stop", 1'h0, frd);
    chk("mrst_no_start", 1'h0, sok);
    $display("test fill done");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #2000000;
    num_errors++;
    conclude();
  end
  initial begin
    {rst_n, want, act, bank, pdone, wreq, held, hit, wb, wdone, drq, dboth, miss, beat} = '0;
    mrst_n = 1'h1;
    nx(16);
    chk("reset_grant", 1'h1, pins.bus_grant_n);
    chk("reset_ad_float", 1'h1, pins.ad_oe_n);
    chk("reset_strobe_float", 1'h1, pins.ctrl_oe_n);
    chk("reset_no_start", 1'h0, sok);
    rst_n <= 1'h1;
    nx(2);
    t_release();
    t_reclaim();
    t_busy();
    t_refresh();
    t_write();
    t_fill();
    conclude();
  end
endmodule // external_bus_release_arbiter_tb
`default_nettype wire
